// ==== sipc_pkg.sv ====
package sipc_pkg;

    // Register word indices (printed offsets are not all multiples of four: byte address is index times four)
    localparam logic [7:0] IGN_CFG_IDX   = 8'h48;
    localparam logic [7:0] THR_CFG_IDX   = 8'h49;
    localparam logic [7:0] MODE_CFG_IDX  = 8'h4a;
    localparam logic [7:0] CUR_CFG_IDX   = 8'h4b;
    localparam logic [7:0] PWR_CFG_IDX   = 8'h4e;
    localparam logic [7:0] LOCK_CFG_IDX  = 8'h4f;
    localparam int         ADDR_W        = 10;
    localparam logic [1:0] ADDR_LSB      = 2'h0;

    // Writable bit masks; everything else is reserved
    localparam logic [7:0] IGN_CFG_MASK  = 8'h19;
    localparam logic [7:0] THR_CFG_MASK  = 8'hc7;
    localparam logic [7:0] MODE_CFG_MASK = 8'hff;
    localparam logic [7:0] CUR_CFG_MASK  = 8'hff;
    localparam logic [7:0] PWR_CFG_MASK  = 8'h7f;
    localparam logic [7:0] LOCK_CFG_MASK = 8'h01;

    // Reset values
    localparam logic [7:0] IGN_CFG_RST   = 8'h00;
    localparam logic [7:0] THR_CFG_RST   = 8'h00;
    localparam logic [7:0] MODE_CFG_RST  = 8'h00;
    localparam logic [7:0] CUR_CFG_RST   = 8'h00;
    localparam logic [7:0] PWR_CFG_RST   = 8'h09;
    localparam logic       LOCK_RST      = 1'b0;

    // Analog settings in physical units
    localparam int OL_TIME_US  [4] = '{64, 256, 512, 768};
    localparam int PEAK_MV     [4] = '{50, 150, 350, 550};
    localparam int FILT_US     [4] = '{1, 5, 10, 20};
    localparam int PEAK_T_US   [2] = '{10, 250};
    localparam int KEY_OFF_MS  [4] = '{100, 200, 400, 800};
    localparam int PWR_DOWN_MS [4] = '{100, 200, 300, 400};
    localparam int CUR_STEP_UA     = 10;
    localparam int CUR_HI_STEP_UA  = 20;
    localparam int CUR_HI_BASE_UA  = 100;
    localparam int CUR_MAX_UA      = 160;
    localparam logic [3:0] CUR_HI_CODE  = 4'h8;
    localparam logic [3:0] CUR_SAT_CODE = 4'hc;

    typedef enum logic [1:0] {
        SIPC_SENS_AUTO, SIPC_SENS_SEMI, SIPC_SENS_MANUAL, SIPC_SENS_HALL
    } sipc_sens_mode_t;

    typedef enum logic [1:0] {
        SIPC_DIAG_NORMAL, SIPC_DIAG_SHORT, SIPC_DIAG_OPENLOAD, SIPC_DIAG_ADC
    } sipc_diag_mode_t;

    typedef struct packed {
        logic [1:0] ign_openload_time_sel;
        logic       ign_openload_enable;
        logic [1:0] sensor_peak_voltage_sel;
        logic [1:0] sensor_filter_time_sel;
        logic       sensor_peak_time_sel;
        logic [3:0] short_test_current_sel;
        sipc_sens_mode_t sensor_type_mode_sel;
        sipc_diag_mode_t sensor_diag_mode_sel;
        logic [3:0] adc_test_current_sel;
        logic [3:0] openload_test_current_sel;
        logic [1:0] key_off_delay_sel;
        logic       engine_off_timer_start_src;
        logic       afterrun_reset_sel;
        logic       afterrun_enable;
        logic [1:0] power_down_time_sel;
    } sipc_cfg_t;

    typedef struct packed {
        logic [15:0] ign_openload_time_us;
        logic [9:0]  sensor_peak_voltage_mv;
        logic [4:0]  sensor_filter_time_us;
        logic [7:0]  sensor_peak_time_us;
        logic [7:0]  short_test_current_ua;
        logic [7:0]  adc_test_current_ua;
        logic [7:0]  openload_test_current_ua;
        logic [9:0]  key_off_delay_ms;
        logic [9:0]  power_down_time_ms;
    } sipc_phys_t;

    typedef struct packed {
        logic [7:0] ign_q;
        logic [7:0] thr_q;
        logic [7:0] mode_q;
        logic [7:0] cur_q;
        logic [7:0] pwr_q;
        logic       lock_q;
        logic       wr_refused_q;
    } sipc_state_t;

endpackage

// ==== sipc_regbank.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Ignition bits 4:3 pick open-load time 64, 256, 512, 768 us; reset 00.
// - Ignition bit 0 enables open-load detection on ignition outputs; reset 0.
// - Threshold bits 7:6 pick peak voltage 50, 150, 350, 550 mV; reset 00.
// - Threshold bits 2:1 pick filter time 1, 5, 10, 20 us; reset 00.
// - Threshold bit 0 picks peak time 10 us or 250 us; reset 0.
// - Mode bits 7:4 set short test current, 10-80 step 10, 100-160 step 20, saturating.
// - Mode bits 3:2 pick sensor mode auto, semi, manual or Hall; reset 00.
// - Mode bits 1:0 pick diagnosis normal, short, open load or ADC; reset 00.
// - Current bits 7:4 set ADC current, same mapping, saturating at 160 uA.
// - Current bits 3:0 set open-load current, same mapping; reset 0000.
// - Power bits 6:5 pick key-off delay 100, 200, 400, 800 ms; reset 00.
// - Power bit 4: timer starts on key falling edge or on start command.
// - Power bit 3 selects afterrun reset; resets to one.
// - Power bit 2 enables afterrun mode; reset 0.
// - Power bits 1:0 pick power-down time 100 to 400 ms; reset 01.
// - Configuration writes are refused while the lock bit is one.
module sipc_regbank
    import sipc_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              nrst_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    output sipc_cfg_t              cfg_o,
    output sipc_phys_t             phys_o,
    output logic                   lock_o,
    output logic                   wr_refused_o
);

    sipc_state_t s_q;
    sipc_state_t s_d;

    logic              access;
    logic              wr;
    logic [ADDR_W-3:0] idx;
    logic              hit;
    logic              hit_cfg;
    logic [7:0]        rdata;
    logic [7:0]        wbyte;

    // Map a current code to microamps; upper codes clamp at the maximum
    function automatic logic [7:0] cur_ua(input logic [3:0] code);
        logic [7:0] v;
        v = 8'h00;
        if (code >= CUR_SAT_CODE) begin
            v = 8'(CUR_MAX_UA);
        end else if (code >= CUR_HI_CODE) begin
            v = 8'(CUR_HI_BASE_UA + CUR_HI_STEP_UA * int'(code - CUR_HI_CODE));
        end else begin
            v = 8'(CUR_STEP_UA * (int'(code) + 1));
        end
        return v;
    endfunction

    assign access = psel_i & penable_i;
    assign wr     = access & pwrite_i & pstrb_i[0];
    assign idx    = paddr_i[ADDR_W-1:2];
    assign wbyte  = pwdata_i[7:0];

    always_comb begin
        hit     = 1'b1;
        hit_cfg = 1'b1;
        rdata   = 8'h00;
        unique case ({idx, ADDR_LSB})
            {IGN_CFG_IDX, ADDR_LSB}:  rdata = s_q.ign_q;
            {THR_CFG_IDX, ADDR_LSB}:  rdata = s_q.thr_q;
            {MODE_CFG_IDX, ADDR_LSB}: rdata = s_q.mode_q;
            {CUR_CFG_IDX, ADDR_LSB}:  rdata = s_q.cur_q;
            {PWR_CFG_IDX, ADDR_LSB}:  rdata = s_q.pwr_q;
            {LOCK_CFG_IDX, ADDR_LSB}: begin
                rdata   = {6'h00, s_q.wr_refused_q, s_q.lock_q};
                hit_cfg = 1'b0;
            end
            default: begin
                hit     = 1'b0;
                hit_cfg = 1'b0;
            end
        endcase
        if (paddr_i[1:0] != ADDR_LSB) begin
            hit     = 1'b0;
            hit_cfg = 1'b0;
            rdata   = 8'h00;
        end
    end

    always_comb begin
        s_d = s_q;
        if (wr && hit_cfg) begin
            s_d.wr_refused_q = s_q.lock_q;
        end
        // Lock blocks every configuration register but not itself
        if (wr && hit_cfg && !s_q.lock_q) begin
            unique case (idx[7:0])
                IGN_CFG_IDX:  s_d.ign_q  = wbyte & IGN_CFG_MASK;
                THR_CFG_IDX:  s_d.thr_q  = wbyte & THR_CFG_MASK;
                MODE_CFG_IDX: s_d.mode_q = wbyte & MODE_CFG_MASK;
                CUR_CFG_IDX:  s_d.cur_q  = wbyte & CUR_CFG_MASK;
                PWR_CFG_IDX:  s_d.pwr_q  = wbyte & PWR_CFG_MASK;
                default:      s_d.wr_refused_q = s_q.wr_refused_q;
            endcase
        end
        if (wr && hit && !hit_cfg) begin
            s_d.lock_q = (wbyte & LOCK_CFG_MASK) != 8'h00;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q.ign_q        <= IGN_CFG_RST;
            s_q.thr_q        <= THR_CFG_RST;
            s_q.mode_q       <= MODE_CFG_RST;
            s_q.cur_q        <= CUR_CFG_RST;
            s_q.pwr_q        <= PWR_CFG_RST;
            s_q.lock_q       <= LOCK_RST;
            s_q.wr_refused_q <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Zero-wait slave; read data is combinational from registers
    assign pready_o  = 1'b1;
    assign pslverr_o = access & ~hit;
    assign prdata_o  = {24'h000000, (access & ~pwrite_i) ? rdata : 8'h00};

    always_comb begin
        cfg_o.ign_openload_time_sel      = s_q.ign_q[4:3];
        cfg_o.ign_openload_enable        = s_q.ign_q[0];
        cfg_o.sensor_peak_voltage_sel    = s_q.thr_q[7:6];
        cfg_o.sensor_filter_time_sel     = s_q.thr_q[2:1];
        cfg_o.sensor_peak_time_sel       = s_q.thr_q[0];
        cfg_o.short_test_current_sel     = s_q.mode_q[7:4];
        cfg_o.sensor_type_mode_sel       = sipc_sens_mode_t'(s_q.mode_q[3:2]);
        cfg_o.sensor_diag_mode_sel       = sipc_diag_mode_t'(s_q.mode_q[1:0]);
        cfg_o.adc_test_current_sel       = s_q.cur_q[7:4];
        cfg_o.openload_test_current_sel  = s_q.cur_q[3:0];
        cfg_o.key_off_delay_sel          = s_q.pwr_q[6:5];
        cfg_o.engine_off_timer_start_src = s_q.pwr_q[4];
        cfg_o.afterrun_reset_sel         = s_q.pwr_q[3];
        cfg_o.afterrun_enable            = s_q.pwr_q[2];
        cfg_o.power_down_time_sel        = s_q.pwr_q[1:0];
    end

    always_comb begin
        phys_o.ign_openload_time_us     = 16'(OL_TIME_US[s_q.ign_q[4:3]]);
        phys_o.sensor_peak_voltage_mv   = 10'(PEAK_MV[s_q.thr_q[7:6]]);
        phys_o.sensor_filter_time_us    = 5'(FILT_US[s_q.thr_q[2:1]]);
        phys_o.sensor_peak_time_us      = 8'(PEAK_T_US[s_q.thr_q[0]]);
        phys_o.short_test_current_ua    = cur_ua(s_q.mode_q[7:4]);
        phys_o.adc_test_current_ua      = cur_ua(s_q.cur_q[7:4]);
        phys_o.openload_test_current_ua = cur_ua(s_q.cur_q[3:0]);
        phys_o.key_off_delay_ms         = 10'(KEY_OFF_MS[s_q.pwr_q[6:5]]);
        phys_o.power_down_time_ms       = 10'(PWR_DOWN_MS[s_q.pwr_q[1:0]]);
    end

    assign lock_o       = s_q.lock_q;
    assign wr_refused_o = s_q.wr_refused_q;

endmodule

// ==== sipc_regbank_checker.sv ====
`timescale 1ns/1ps
module sipc_regbank_checker
    import sipc_pkg::*;
(
    input wire logic              core_clk_i,
    input wire logic              nrst_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0]       pwdata_i,
    input wire logic [3:0]        pstrb_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire sipc_cfg_t         cfg_o,
    input wire sipc_phys_t        phys_o,
    input wire logic              lock_o,
    input wire logic              wr_refused_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    logic acc;
    logic ign_sel;
    assign acc = psel_i && penable_i;
    assign ign_sel = paddr_i == {IGN_CFG_IDX, 2'h0};
    property p_ready; acc |-> pready_o; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_rd_upper; acc && !pwrite_i |-> prdata_o[31:8] == 24'h0; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_ign_read; acc && !pwrite_i && ign_sel |->
        prdata_o[7:0] == {3'h0, cfg_o.ign_openload_time_sel, 2'h0, cfg_o.ign_openload_enable}; endproperty
    a_ign_read: assert property (p_ign_read) else $error("ignition readback wrong");
    property p_ign_write; acc && pwrite_i && pstrb_i[0] && ign_sel && !lock_o |=>
        {cfg_o.ign_openload_time_sel, cfg_o.ign_openload_enable} == {$past(pwdata_i[4:3]), $past(pwdata_i[0])};
    endproperty
    a_ign_write: assert property (p_ign_write) else $error("ignition write lost");
    property p_locked; acc && pwrite_i && pstrb_i[0] && ign_sel && lock_o |=> $stable(cfg_o) && wr_refused_o;
    endproperty
    a_locked: assert property (p_locked) else $error("locked write took effect");
    property p_reset; $rose(nrst_i) |-> cfg_o.afterrun_reset_sel && cfg_o.power_down_time_sel == 2'h1; endproperty
    a_reset: assert property (p_reset) else $error("power mode reset wrong");
    property p_peak; phys_o.sensor_peak_time_us == (cfg_o.sensor_peak_time_sel ? 8'hfa : 8'h0a); endproperty
    a_peak: assert property (p_peak) else $error("peak time wrong");
    property p_sat; cfg_o.adc_test_current_sel >= 4'hc |-> phys_o.adc_test_current_ua == 8'ha0; endproperty
    a_sat: assert property (p_sat) else $error("adc current not saturated");
    property p_keyoff; phys_o.key_off_delay_ms == 10'h64 << cfg_o.key_off_delay_sel; endproperty
    a_keyoff: assert property (p_keyoff) else $error("key off delay wrong");
endmodule
bind sipc_regbank sipc_regbank_checker u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cfg_o(cfg_o), .phys_o(phys_o),
    .lock_o(lock_o), .wr_refused_o(wr_refused_o));

// ==== sipc_sensor_model.sv ====
`timescale 1ns/1ps
module sipc_sensor_model
    import sipc_pkg::*;
(
    input  wire sipc_cfg_t  cfg_i,
    input  wire sipc_phys_t phys_i,
    output logic [9:0]      arm_level_mv_o
);
    // Hall sensors switch digitally, so the peak threshold is ignored
    assign arm_level_mv_o = (cfg_i.sensor_type_mode_sel == SIPC_SENS_HALL) ? 10'h0 : phys_i.sensor_peak_voltage_mv;
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import sipc_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [9:0]  paddr = 10'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata, v;
    logic        pready, pslverr, lock, refused;
    sipc_cfg_t   cfg;
    sipc_phys_t  phys;
    logic [9:0]  arm_mv;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int          n_fail = 0, total_checks = 0, seed = 90;
    logic [9:0]  addr [5] = '{10'h120, 10'h124, 10'h128, 10'h12c, 10'h138};
    logic [7:0]  msk [5] = '{IGN_CFG_MASK, THR_CFG_MASK, MODE_CFG_MASK, CUR_CFG_MASK, PWR_CFG_MASK};
    logic [7:0]  rstv [5] = '{IGN_CFG_RST, THR_CFG_RST, MODE_CFG_RST, CUR_CFG_RST, PWR_CFG_RST};
    always #50 clk = ~clk;
    sipc_regbank dut (.core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .cfg_o(cfg), .phys_o(phys), .lock_o(lock), .wr_refused_o(refused));
    sipc_sensor_model u_sensor (.cfg_i(cfg), .phys_i(phys), .arm_level_mv_o(arm_mv));
    task check(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Idle edge at the end keeps psel from being driven twice in one step
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [9:0] a, input logic [32:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, 32'h0, 4'hf);
    endtask
    always @(posedge clk) begin
        if (psel && pen && !pwr && pready === 1'b1) begin
            e = exp_q.pop_front();
            check({pslverr, prdata}, e);
        end
    end
    initial begin
        #(100 * 20000);
        n_fail++;
        end_sim;
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) rd(addr[i], {25'h0, rstv[i]});
        $display("test reset values done");
        repeat (4) for (int i = 0; i < 5; i++) begin
            v = $random(seed);
            apb(1'b1, addr[i], v, 4'hf);
            rd(addr[i], {25'h0, v[7:0] & msk[i]});
        end
        $display("test random readback done");
        // Same nibble in both halves walks every code of every field
        for (int c = 0; c < 16; c++) begin
            for (int i = 0; i < 5; i++) apb(1'b1, addr[i], {24'h0, c[3:0], c[3:0]}, 4'hf);
            e = 33'((c < 8) ? 10 * (c + 1) : (c < 12) ? 100 + 20 * (c - 8) : 160);
            check({25'h0, phys.adc_test_current_ua}, e);
            check({25'h0, phys.openload_test_current_ua}, e);
            check({25'h0, phys.short_test_current_ua}, e);
            check({23'h0, phys.power_down_time_ms}, 33'(100 * (c[1:0] + 1)));
            check({23'h0, phys.key_off_delay_ms}, 33'(100 << c[2:1]));
            check({23'h0, arm_mv}, 33'((c[3:2] == 2'h3) ? 0 : PEAK_MV[c[3:2]]));
            check({28'h0, phys.sensor_filter_time_us}, 33'(FILT_US[c[2:1]]));
            check({17'h0, phys.ign_openload_time_us}, 33'(OL_TIME_US[{c[0], c[3]}]));
            check({25'h0, phys.sensor_peak_time_us}, 33'(PEAK_T_US[c[0]]));
            check({31'h0, cfg.engine_off_timer_start_src, cfg.afterrun_enable}, 33'({c[0], c[2]}));
            check({31'h0, cfg.sensor_diag_mode_sel}, 33'(c[1:0]));
        end
        $display("test code mapping done");
        apb(1'b1, {LOCK_CFG_IDX, 2'h0}, 32'h1, 4'hf);
        check({32'h0, lock}, 33'h1);
        apb(1'b1, addr[0], 32'h0, 4'hf);
        rd(addr[0], 33'h19);
        check({32'h0, refused}, 33'h1);
        apb(1'b1, {LOCK_CFG_IDX, 2'h0}, 32'h0, 4'hf);
        check({32'h0, lock}, 33'h0);
        apb(1'b1, addr[0], 32'h0, 4'he);
        rd(addr[0], 33'h19);
        apb(1'b1, addr[0], 32'h0, 4'hf);
        check({32'h0, refused}, 33'h0);
        rd(addr[0], 33'h0);
        rd(10'h0, {1'b1, 32'h0});
        $display("test lock done");
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(addr[4], 33'h09);
        $display("test second reset done");
        end_sim;
    end
endmodule
